// *** sool_top.sv ***
// Serial octal output latch: eight channel latches loaded over a serial link.
// Assumes the link pins are asynchronous to clk and sampled twice here;
// the disable pin also acts without the clock. Rising link clock samples.
//
// Function
// - Eight independent channels follow serial data
// - Per-channel latch, common reset from disable
// - Latched one on, latched zero off
// - Disable low forces all outputs off asynchronously
// - Disable also clears the input registers
// - Outputs stay off until new valid word
// - Transfers accepted only while select low
// - Input bit sampled on rising link clock
// - Serial output changes after falling link clock
// - Serial output driven only while selected
// - Serial output carries shifted-out bits
// - Select rising edge copies shift register
// - Outputs held off until interface settled
// - Most significant bit first both directions
// - Load only when pulse count multiple of eight
// - Ignore link clock and data while deselected
`timescale 1ns/1ps
module sool_top (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic all_outputs_off_n,
  input  wire logic chip_select_n,
  input  wire logic serial_clock,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      channel_switch_0,
  output logic      channel_switch_1,
  output logic      channel_switch_2,
  output logic      channel_switch_3,
  output logic      channel_switch_4,
  output logic      channel_switch_5,
  output logic      channel_switch_6,
  output logic      channel_switch_7
);

  logic                           sel_n_sync;
  logic                           sclk_sync;
  logic                           sdi_sync;
  logic                           dis_n_sync;
  logic                           sel_n_prev_reg;
  logic                           sclk_prev_reg;
  logic                           sclk_rise;
  logic                           sclk_fall;
  logic                           sel_fall;
  logic                           sel_rise;
  logic                           dis_clear;
  logic                           shift_step;
  logic                           frame_load;
  logic [sool_pkg::CHANNELS-1:0]  shift_reg;
  logic [sool_pkg::CHANNELS-1:0]  latch_reg;
  logic [sool_pkg::CNT_W-1:0]     count_reg;
  logic                           settled_reg;
  logic [sool_pkg::SETTLE_W-1:0]  settle_cnt_reg;
  sool_pkg::sool_state_t          state_reg;

  // Select idles high; the synchroniser must agree so no false edge appears
  sool_sync u_sync_sel (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .reset_value (1'b1),
    .async_in    (chip_select_n),
    .sync_out    (sel_n_sync)
  );

  sool_sync u_sync_sclk (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .reset_value (1'b1),
    .async_in    (serial_clock),
    .sync_out    (sclk_sync)
  );

  // Data takes the same two flops as the link clock, so both stay aligned
  sool_sync u_sync_sdi (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .reset_value (1'b0),
    .async_in    (serial_in),
    .sync_out    (sdi_sync)
  );

  sool_sync u_sync_dis (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .reset_value (1'b1),
    .async_in    (all_outputs_off_n),
    .sync_out    (dis_n_sync)
  );

  // Edge history starts at the idle level of select and link clock, the
  // level the synchronisers reset to, so reset makes no false edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_n_prev_reg <= 1'b1;
      sclk_prev_reg  <= 1'b1;
    end else if (clk_en) begin
      sel_n_prev_reg <= sel_n_sync;
      sclk_prev_reg  <= sclk_sync;
    end
  end

  // Link clock edges seen only while selected; deselected activity is dropped
  assign sclk_rise = sclk_sync & ~sclk_prev_reg & ~sel_n_sync;
  assign sclk_fall = ~sclk_sync & sclk_prev_reg & ~sel_n_sync;
  assign sel_fall  = ~sel_n_sync & sel_n_prev_reg;
  assign sel_rise  = sel_n_sync & ~sel_n_prev_reg;
  // Synchronised copy clears the input side; outputs use the raw pin too
  assign dis_clear = ~dis_n_sync;
  // Link clock edges count only inside a frame that began after settle
  assign shift_step = (state_reg == sool_pkg::SOOL_SELECTED) & sclk_rise;
  // A frame loads only on release after a whole number of bytes
  assign frame_load = (state_reg == sool_pkg::SOOL_SELECTED) & sel_rise
                    & (count_reg == sool_pkg::COUNT_WRAP);

  // Power-up settle: output stage stays off until the counter expires
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settle_cnt_reg <= '0;
      settled_reg    <= 1'b0;
    end else if (clk_en && !settled_reg) begin
      if (settle_cnt_reg == sool_pkg::SETTLE_LAST) begin
        settled_reg <= 1'b1;
      end else begin
        settle_cnt_reg <= settle_cnt_reg + 1'b1;
      end
    end
  end

  // Link framing state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= sool_pkg::SOOL_SETTLE;
    end else if (clk_en) begin
      case (state_reg)
        // A select fall during settle is never seen again, so a frame
        // begun that early is refused whole instead of loading half a word
        sool_pkg::SOOL_SETTLE: begin
          if (settled_reg) begin
            state_reg <= sool_pkg::SOOL_IDLE;
          end
        end
        sool_pkg::SOOL_IDLE: begin
          if (sel_fall) begin
            state_reg <= sool_pkg::SOOL_SELECTED;
          end
        end
        sool_pkg::SOOL_SELECTED: begin
          if (sel_rise) begin
            state_reg <= sool_pkg::SOOL_IDLE;
          end
        end
        default: begin
          state_reg <= sool_pkg::SOOL_IDLE;
        end
      endcase
    end
  end

  // Shift register: MSB first in, MSB first out
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_reg <= sool_pkg::SHIFT_RESET;
    end else if (clk_en) begin
      if (dis_clear) begin
        shift_reg <= sool_pkg::SHIFT_RESET;
      end else if (shift_step) begin
        // First bit ends in bit 7 after eight shifts
        shift_reg <= {shift_reg[sool_pkg::CHANNELS-2:0], sdi_sync};
      end
    end
  end

  // Modulo-eight pulse counter over the select window
  // The counter wraps every eight pulses, so zero means whole bytes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= sool_pkg::COUNT_RESET;
    end else if (clk_en) begin
      if (dis_clear || sel_fall) begin
        count_reg <= sool_pkg::COUNT_RESET;
      end else if (shift_step) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // Channel latches; disable clears them, a valid frame loads them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_reg <= sool_pkg::LATCH_RESET;
    end else if (clk_en) begin
      // Disable wins over a load arriving in the same cycle
      if (dis_clear) begin
        latch_reg <= sool_pkg::LATCH_RESET;
      end else if (frame_load) begin
        // A frame of zero pulses also loads; the shift register holds
        latch_reg <= shift_reg;
      end
    end
  end

  // Pin driver enable follows select; the pin floats outside a frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_out_oe <= 1'b0;
    end else if (clk_en) begin
      serial_out_oe <= ~sel_n_sync;
    end
  end

  // Serial output: current MSB, updated on falling link clock.
  // Select fall presents the first bit before any link clock edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_out <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall || sclk_fall) begin
        serial_out <= shift_reg[sool_pkg::CHANNELS-1];
      end
    end
  end

  // Output stage: one flop per channel, each cleared by the raw disable pin
  // without waiting for a clock. Bit n of the latch drives channel n, a one
  // switches it on, and nothing reaches a channel before settle ends.
  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_0 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_0 <= settled_reg & latch_reg[0];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_1 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_1 <= settled_reg & latch_reg[1];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_2 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_2 <= settled_reg & latch_reg[2];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_3 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_3 <= settled_reg & latch_reg[3];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_4 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_4 <= settled_reg & latch_reg[4];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_5 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_5 <= settled_reg & latch_reg[5];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_6 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_6 <= settled_reg & latch_reg[6];
    end
  end

  always_ff @(posedge clk or posedge reset or negedge all_outputs_off_n) begin
    if (reset || !all_outputs_off_n) begin
      channel_switch_7 <= 1'b0;
    end else if (clk_en) begin
      channel_switch_7 <= settled_reg & latch_reg[7];
    end
  end

endmodule

// *** sool_pkg.sv ***
// Package for the serial octal output latch: widths, reset values, counts.
// Assumes a single 40 MHz system clock samples every link pin.
package sool_pkg;

  localparam int unsigned CHANNELS      = 8;
  localparam int unsigned CNT_W         = 3;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam logic [7:0]  SHIFT_RESET   = 8'h00;
  localparam logic [2:0]  COUNT_RESET   = 3'h0;
  localparam logic [2:0]  COUNT_WRAP    = 3'h0;
  // Power-up settle time before the output stage may follow the latches
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 6;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST =
    SETTLE_W'(SETTLE_CYCLES - 1);

  typedef enum logic [1:0] {
    SOOL_SETTLE,
    SOOL_IDLE,
    SOOL_SELECTED
  } sool_state_t;

endpackage

// *** sool_sync.sv ***
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes clk, reset and the shared clock enable of the top module.
`timescale 1ns/1ps
module sool_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic reset_value,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;
  logic hold_reg;

  // Flops hold the level relative to the tied reset value, so the reset
  // branch stays constant while the output starts at the pin's idle level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in ^ reset_value;
      hold_reg <= meta_reg;
    end
  end

  assign sync_out = hold_reg ^ reset_value;

endmodule

// *** sool_properties.sv ***
// Assertions on the ports of sool_top, bound to every instance.
// Assumes clk_en high and link pins far slower than clk.
`timescale 1ns/1ps
module sool_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic all_outputs_off_n,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic channel_switch_0,
  input wire logic channel_switch_1,
  input wire logic channel_switch_2,
  input wire logic channel_switch_3,
  input wire logic channel_switch_4,
  input wire logic channel_switch_5,
  input wire logic channel_switch_6,
  input wire logic channel_switch_7
);
  logic [7:0] ch;
  logic [5:0] age_reg;
  assign ch = {channel_switch_7, channel_switch_6, channel_switch_5,
    channel_switch_4, channel_switch_3, channel_switch_2,
    channel_switch_1, channel_switch_0};
  // Cycles since reset, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) age_reg <= 6'h00;
    else if (age_reg != 6'h3F) age_reg <= age_reg + 6'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_dis_off; !all_outputs_off_n |-> ch == 8'h00; endproperty
  a_dis_off: assert property (p_dis_off) else $error("on while off");
  property p_settle; age_reg < 6'h26 |-> ch == 8'h00; endproperty
  a_settle: assert property (p_settle) else $error("early on");
  property p_dis_hold;
    $rose(all_outputs_off_n) && chip_select_n |-> (ch == 8'h00)[*4];
  endproperty
  a_dis_hold: assert property (p_dis_hold) else $error("old data");
  property p_oe_off; chip_select_n[*6] |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe idle");
  property p_oe_on; $fell(chip_select_n) |-> ##[2:5] serial_out_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_oe_drop;
    $rose(chip_select_n) |-> ##[3:8] !serial_out_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("oe stuck");
  property p_so_fall;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
      |-> !serial_clock;
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved");
  property p_ch_cs;
    $changed(ch) && all_outputs_off_n && $past(all_outputs_off_n)
      |-> chip_select_n && $past(chip_select_n, 2);
  endproperty
  a_ch_cs: assert property (p_ch_cs) else $error("load early");
  c_load: cover property ($changed(ch) && ch != 8'h00);
  c_dis: cover property ($fell(all_outputs_off_n));
  c_oe: cover property ($fell(serial_out_oe));
endmodule
bind sool_top sool_checker chk_i (.clk(clk), .reset(reset),
  .all_outputs_off_n(all_outputs_off_n), .chip_select_n(chip_select_n),
  .serial_clock(serial_clock), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .channel_switch_0(channel_switch_0),
  .channel_switch_1(channel_switch_1), .channel_switch_2(channel_switch_2),
  .channel_switch_3(channel_switch_3), .channel_switch_4(channel_switch_4),
  .channel_switch_5(channel_switch_5), .channel_switch_6(channel_switch_6),
  .channel_switch_7(channel_switch_7));

// *** sool_master.sv ***
// Serial link master model driving the octal latch.
// Assumes clk is the bench clock; half a link period is four clk cycles.
`timescale 1ns/1ps
module sool_master (
  input  wire logic clk,
  input  wire logic serial_out,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_in
);
  logic [15:0] rx;
  initial begin
    chip_select_n = 1'b1;
    serial_clock  = 1'b1;
    serial_in     = 1'b0;
    rx            = 16'h0000;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #2;
  endtask
  // Low n bits of w go out first-highest; returned bits collect in rx
  task automatic frame(input logic [15:0] w, input int n);
    chip_select_n = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      serial_clock = 1'b0;
      serial_in    = w[i];
      half();
      rx           = {rx[14:0], serial_out};
      serial_clock = 1'b1;
      half();
    end
    chip_select_n = 1'b1;
    serial_in     = ~serial_in;
    repeat (3) half();
  endtask
  // Link activity while deselected, which the latch must ignore
  task automatic wiggle();
    for (int i = 0; i < 4; i++) begin
      serial_clock = 1'b0;
      serial_in    = i[0];
      half();
      serial_clock = 1'b1;
      half();
    end
  endtask
endmodule

// *** serial_octal_output_latch_test.sv ***
// Self-checking bench for sool_top with a link master model.
// Assumes the checker is bound through its own file.
`timescale 1ns/1ps
module serial_octal_output_latch_test;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       dis_n = 1'b1;
  logic       cs_n, sclk, si, so, so_oe;
  wire  [7:0] ch;
  int         n_mismatch = 0;
  int         checked = 0;
  // Nobody drives the pin while deselected
  wire        so_pin = so_oe ? so : 1'bz;
  always #12.5 clk = ~clk;
  sool_top dut (.clk(clk), .reset(reset), .clk_en(1'b1),
    .all_outputs_off_n(dis_n), .chip_select_n(cs_n), .serial_clock(sclk),
    .serial_in(si), .serial_out(so), .serial_out_oe(so_oe),
    .channel_switch_0(ch[0]), .channel_switch_1(ch[1]),
    .channel_switch_2(ch[2]), .channel_switch_3(ch[3]),
    .channel_switch_4(ch[4]), .channel_switch_5(ch[5]),
    .channel_switch_6(ch[6]), .channel_switch_7(ch[7]));
  sool_master m (.clk(clk), .serial_out(so_pin), .chip_select_n(cs_n),
    .serial_clock(sclk), .serial_in(si));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("%0d mismatches in %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A frame begun during the power-up settle time must be refused
  task automatic t_early();
    m.frame(16'h00FF, 8);
    chk(ch, 8'h00);
  endtask
  task automatic t_load();
    m.frame(16'h00A5, 8);
    chk(ch, 8'hA5);
    m.frame(16'h003C, 8);
    chk(m.rx[7:0], 8'hA5);
    chk(ch, 8'h3C);
  endtask
  task automatic t_count();
    m.frame(16'h007F, 7);
    chk(ch, 8'h3C);
    m.frame(16'hF0C3, 16);
    chk(ch, 8'hC3);
  endtask
  task automatic t_desel();
    m.wiggle();
    m.frame(16'h0081, 8);
    chk(m.rx[7:0], 8'hC3);
    chk(ch, 8'h81);
  endtask
  task automatic t_dis();
    dis_n = 1'b0;
    #1 chk(ch, 8'h00);
    repeat (10) @(posedge clk);
    #2 dis_n = 1'b1;
    repeat (10) @(posedge clk);
    #2 chk(ch, 8'h00);
    m.frame(16'h0066, 8);
    chk(m.rx[7:0], 8'h00);
    chk(ch, 8'h66);
  endtask
  // Mid-run reset clears the channels and restarts the settle time
  task automatic t_reset();
    reset = 1'b1;
    #1 chk(ch, 8'h00);
    repeat (3) @(posedge clk);
    #2 reset = 1'b0;
    t_early();
    m.frame(16'h005A, 8);
    chk(m.rx[7:0], 8'h00);
    chk(ch, 8'h5A);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #2 reset = 1'b0;
    chk(ch, 8'h00);
    t_early();
    t_load();
    t_count();
    t_desel();
    t_dis();
    t_reset();
    print_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
